// File: core/imdu_unit.sv
`timescale 1ns/1ps
`include "imdu_consts.svh"

module imdu_unit
    import imdu_pkg::*;
(
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      resetn_i,
    // issue from pipeline
    input  wire logic      req_valid_i,
    input  imdu_req_s      req_i,
    output logic           req_ready_o,
    output logic           stall_o,
    // register file port
    output imdu_wb_s       wb_o,
    // result pair, for observation
    output logic [31:0]    upper_result_register_o,
    output logic [31:0]    lower_result_register_o,
    output logic           busy_o
);

    // ****************************************
    // operand decode
    // ****************************************
    logic        is_uns;
    logic        is_div;
    logic        is_move;
    logic        short_ops;
    logic [63:0] op_a;
    logic [63:0] op_b;
    logic [63:0] product;

    always_comb begin
        is_uns = (req_i.op == IMDU_OP_UNSIGNED_MULTIPLY) ||
                 (req_i.op == IMDU_OP_UNSIGNED_MULTIPLY_ACCUMULATE) ||
                 (req_i.op == IMDU_OP_UNSIGNED_MULTIPLY_SUBTRACT) ||
                 (req_i.op == IMDU_OP_UNSIGNED_DIVIDE);
        is_div = (req_i.op == IMDU_OP_SIGNED_DIVIDE) ||
                 (req_i.op == IMDU_OP_UNSIGNED_DIVIDE);
        is_move = (req_i.op == IMDU_OP_MOVE_FROM_UPPER_RESULT) ||
                  (req_i.op == IMDU_OP_MOVE_FROM_LOWER_RESULT);
        // operands fit 16 bits when upper half is a pure extension
        if (is_uns) begin
            short_ops = (req_i.rs[31:16] == 16'h0000) &&
                        (req_i.rt[31:16] == 16'h0000);
        end else begin
            short_ops = (req_i.rs[31:16] == {16{req_i.rs[15]}}) &&
                        (req_i.rt[31:16] == {16{req_i.rt[15]}});
        end
        op_a = is_uns ? {32'h0000_0000, req_i.rs}
                      : {{32{req_i.rs[31]}}, req_i.rs};
        op_b = is_uns ? {32'h0000_0000, req_i.rt}
                      : {{32{req_i.rt[31]}}, req_i.rt};
        product = op_a * op_b;
    end

    // ****************************************
    // issue timing and result pipeline
    // ****************************************
    // pending result is held until its latency elapses; the result pair
    // stays stale until then, so moves interlock on pend_q
    logic [5:0]  rep_q,  rep_d;
    logic [5:0]  lat_q,  lat_d;
    logic [5:0]  stl_q,  stl_d;
    logic        pend_q, pend_d;
    logic        preg_q, preg_d;
    logic [4:0]  prd_q,  prd_d;
    logic [63:0] pres_q, pres_d;
    logic [31:0] hi_q,   hi_d;
    logic [31:0] lo_q,   lo_d;
    imdu_wb_s    wb_q,   wb_d;
    logic        accept;
    logic [63:0] pair;
    logic [63:0] div_res;
    logic [31:0] quo;
    logic [31:0] rem;
    logic [31:0] abs_a;
    logic [31:0] abs_b;

    assign pair = {hi_q, lo_q};

    always_comb begin
        abs_a = (!is_uns && req_i.rs[31]) ? 32'(-req_i.rs) : req_i.rs;
        abs_b = (!is_uns && req_i.rt[31]) ? 32'(-req_i.rt) : req_i.rt;
        if (req_i.rt == 32'h0000_0000) begin
            quo = 32'hFFFF_FFFF;
            rem = req_i.rs;
        end else begin
            quo = abs_a / abs_b;
            rem = abs_a % abs_b;
            if (!is_uns && (req_i.rs[31] ^ req_i.rt[31])) begin
                quo = 32'(-quo);
            end
            if (!is_uns && req_i.rs[31]) begin
                rem = 32'(-rem);
            end
        end
        div_res = {rem, quo};
    end

    // interlock: repeat interval, pending stall, or move on stale pair
    always_comb begin
        // a register multiply must not clobber a pending pair result
        req_ready_o = (rep_q == 6'd0) && (stl_q == 6'd0) &&
                      !(is_move && pend_q) &&
                      !((req_i.op == IMDU_OP_MULTIPLY_TO_REG) && pend_q &&
                        !preg_q && (lat_q > 6'd1));
        stall_o = req_valid_i && !req_ready_o;
        accept = req_valid_i && req_ready_o;
    end

    always_comb begin
        rep_d  = (rep_q != 6'd0) ? rep_q - 6'd1 : 6'd0;
        lat_d  = (lat_q != 6'd0) ? lat_q - 6'd1 : 6'd0;
        // stall follows the repeat gap, so the register write retires
        // before the next issue can replace the pending result
        stl_d  = (stl_q != 6'd0 && rep_q == 6'd0) ? stl_q - 6'd1 : stl_q;
        pend_d = pend_q;
        preg_d = preg_q;
        prd_d  = prd_q;
        pres_d = pres_q;
        hi_d   = hi_q;
        lo_d   = lo_q;
        wb_d   = '0;
        // retire on the cycle latency reaches one
        if (pend_q && lat_q == 6'd1) begin
            pend_d = 1'b0;
            if (preg_q) begin
                wb_d.we   = 1'b1;
                wb_d.addr = prd_q;
                wb_d.data = pres_q[31:0];
            end else begin
                hi_d = pres_q[63:32];
                lo_d = pres_q[31:0];
            end
        end
        if (accept) begin
            case (req_i.op)
                IMDU_OP_MOVE_FROM_UPPER_RESULT: begin
                    wb_d.we   = 1'b1;
                    wb_d.addr = req_i.rd;
                    wb_d.data = hi_q;
                end
                IMDU_OP_MOVE_FROM_LOWER_RESULT: begin
                    wb_d.we   = 1'b1;
                    wb_d.addr = req_i.rd;
                    wb_d.data = lo_q;
                end
                IMDU_OP_SIGNED_DIVIDE, IMDU_OP_UNSIGNED_DIVIDE: begin
                    pend_d = 1'b1;
                    preg_d = 1'b0;
                    pres_d = div_res;
                    lat_d  = `IMDU_LAT_DIV;
                    rep_d  = `IMDU_REP_DIV - 6'd1;
                end
                IMDU_OP_NONE: begin
                    pend_d = pend_q;
                end
                default: begin
                    pend_d = 1'b1;
                    preg_d = (req_i.op == IMDU_OP_MULTIPLY_TO_REG);
                    prd_d  = req_i.rd;
                    // accumulate reads a pending pair result, else the pair, so the
                    // next accumulate can issue before writeback and still see it
                    case (req_i.op)
                        IMDU_OP_MULTIPLY_ACCUMULATE,
                        IMDU_OP_UNSIGNED_MULTIPLY_ACCUMULATE:
                            pres_d = ((pend_q && !preg_q) ? pres_q : pair)
                                     + product;
                        IMDU_OP_MULTIPLY_SUBTRACT,
                        IMDU_OP_UNSIGNED_MULTIPLY_SUBTRACT:
                            pres_d = ((pend_q && !preg_q) ? pres_q : pair)
                                     - product;
                        default:
                            pres_d = product;
                    endcase
                    if (short_ops) begin
                        lat_d = `IMDU_LAT_MUL16;
                        rep_d = `IMDU_REP_MUL16 - 6'd1;
                    end else begin
                        lat_d = `IMDU_LAT_MUL32;
                        rep_d = `IMDU_REP_MUL32 - 6'd1;
                    end
                    if (preg_d) begin
                        stl_d = short_ops ? `IMDU_STALL_RD16
                                          : `IMDU_STALL_RD32;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rep_q  <= 6'd0;
            lat_q  <= 6'd0;
            stl_q  <= 6'd0;
            pend_q <= 1'b0;
            preg_q <= 1'b0;
            prd_q  <= 5'd0;
            pres_q <= 64'h0000_0000_0000_0000;
            hi_q   <= `IMDU_RES_RST;
            lo_q   <= `IMDU_RES_RST;
            wb_q   <= '0;
        end else begin
            rep_q  <= rep_d;
            lat_q  <= lat_d;
            stl_q  <= stl_d;
            pend_q <= pend_d;
            preg_q <= preg_d;
            prd_q  <= prd_d;
            pres_q <= pres_d;
            hi_q   <= hi_d;
            lo_q   <= lo_d;
            wb_q   <= wb_d;
        end
    end

    // register file lives in the pipeline; this unit drives one write
    // port of its two and relies on its bypass
    assign wb_o                    = wb_q;
    assign upper_result_register_o = hi_q;
    assign lower_result_register_o = lo_q;
    assign busy_o                  = pend_q;

endmodule

// File: pkg/imdu_consts.svh
`ifndef IMDU_CONSTS_SVH
`define IMDU_CONSTS_SVH

// ****************************************
// timing counts, in pipeline clock cycles
// ****************************************
`define IMDU_LAT_MUL16   6'd3
`define IMDU_REP_MUL16   6'd2
`define IMDU_LAT_MUL32   6'd4
`define IMDU_REP_MUL32   6'd3
`define IMDU_STALL_RD16  6'd1
`define IMDU_STALL_RD32  6'd2
`define IMDU_LAT_DIV     6'd36
`define IMDU_REP_DIV     6'd36

// ****************************************
// register count and reset values
// ****************************************
`define IMDU_GPR_COUNT   32
`define IMDU_RES_RST     32'h0000_0000

`endif

// File: pkg/imdu_pkg.sv
package imdu_pkg;

    typedef enum logic [3:0] {
        IMDU_OP_NONE,
        IMDU_OP_SIGNED_MULTIPLY,
        IMDU_OP_UNSIGNED_MULTIPLY,
        IMDU_OP_MULTIPLY_ACCUMULATE,
        IMDU_OP_UNSIGNED_MULTIPLY_ACCUMULATE,
        IMDU_OP_MULTIPLY_SUBTRACT,
        IMDU_OP_UNSIGNED_MULTIPLY_SUBTRACT,
        IMDU_OP_SIGNED_DIVIDE,
        IMDU_OP_UNSIGNED_DIVIDE,
        IMDU_OP_MULTIPLY_TO_REG,
        IMDU_OP_MOVE_FROM_UPPER_RESULT,
        IMDU_OP_MOVE_FROM_LOWER_RESULT
    } imdu_op_e;

    typedef enum logic [1:0] {
        IMDU_ST_IDLE,
        IMDU_ST_BUSY
    } imdu_state_e;

    typedef struct packed {
        imdu_op_e    op;
        logic [31:0] rs;
        logic [31:0] rt;
        logic [4:0]  rd;
    } imdu_req_s;

    typedef struct packed {
        logic        we;
        logic [4:0]  addr;
        logic [31:0] data;
    } imdu_wb_s;

endpackage

// File: tb/imdu_unit_props.sv
`timescale 1ns/1ps
module imdu_unit_props
    import imdu_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // issue side
    input  wire logic        req_valid_i,
    input  imdu_req_s        req_i,
    input  wire logic        req_ready_o,
    input  wire logic        stall_o,
    // results
    input  imdu_wb_s         wb_o,
    input  wire logic [31:0] lower_result_register_o,
    input  wire logic        busy_o
);
    logic take;
    logic sh;
    logic smul;
    logic rmul;
    // short only judged for signed operands
    assign take = req_valid_i && req_ready_o;
    assign sh = (req_i.rs[31:15] == {17{req_i.rs[15]}}) &&
                (req_i.rt[31:15] == {17{req_i.rt[15]}});
    assign smul = take && req_i.op == IMDU_OP_SIGNED_MULTIPLY;
    assign rmul = take && req_i.op == IMDU_OP_MULTIPLY_TO_REG;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_stall_flag: assert property (
        stall_o == (req_valid_i && !req_ready_o))
        else $error("stall flag wrong");
    a_short_repeat: assert property (
        smul && sh |=> !req_ready_o)
        else $error("short multiply accepted too soon");
    a_long_repeat: assert property (
        smul && !sh |=> !req_ready_o [*2])
        else $error("long multiply accepted too soon");
    a_short_latency: assert property (
        smul && sh ##1 1'b1 ##1 !take ##1 !take |-> busy_o ##1 !busy_o)
        else $error("short multiply latency wrong");
    a_div_repeat: assert property (
        take && req_i.op inside {IMDU_OP_SIGNED_DIVIDE,
        IMDU_OP_UNSIGNED_DIVIDE} |=> !req_ready_o [*8] ##1 busy_o)
        else $error("divide accepted too soon");
    a_regmul_stall: assert property (
        rmul |=> !req_ready_o [*2])
        else $error("register multiply did not stall");
    a_regmul_keep: assert property (
        rmul |-> ##2 $stable(lower_result_register_o) [*5])
        else $error("register multiply touched lower result");
    a_move_wb: assert property (
        take && req_i.op == IMDU_OP_MOVE_FROM_LOWER_RESULT |=> wb_o.we
        && wb_o.addr == $past(req_i.rd)
        && wb_o.data == lower_result_register_o)
        else $error("move did not write lower result");
    a_move_hold: assert property (
        req_valid_i && busy_o && req_i.op inside
        {IMDU_OP_MOVE_FROM_UPPER_RESULT, IMDU_OP_MOVE_FROM_LOWER_RESULT}
        |-> stall_o)
        else $error("move not held while result pending");
endmodule
bind imdu_unit imdu_unit_props u_imdu_unit_props (.clk_i, .resetn_i,
    .req_valid_i, .req_i, .req_ready_o, .stall_o, .wb_o,
    .lower_result_register_o, .busy_o);

// File: tb/imdu_gpr_model.sv
`timescale 1ns/1ps
`include "imdu_consts.svh"
module imdu_gpr_model
    import imdu_pkg::*;
(
    // clock
    input  wire logic clk_i,
    // write port from the unit
    input  imdu_wb_s  wb_i
);
    // second write port belongs to the alu, not modelled
    logic [31:0] regs_q [`IMDU_GPR_COUNT];
    always_ff @(posedge clk_i) begin
        if (wb_i.we) begin
            regs_q[wb_i.addr] <= wb_i.data;
        end
    end
endmodule

// File: tb/imdu_unit_test.sv
`timescale 1ns/1ps
module imdu_unit_test
    import imdu_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        req_valid_i = 1'b0;
    imdu_req_s   req_i = '0;
    logic        req_ready_o;
    logic        stall_o;
    logic        busy_o;
    imdu_wb_s    wb_o;
    logic [31:0] up_o;
    logic [31:0] lo_o;
    int          errors = 0;
    int          checks_done = 0;
    int          w;
    imdu_unit u_imdu_unit (.clk_i, .resetn_i, .req_valid_i, .req_i,
        .req_ready_o, .stall_o, .wb_o, .upper_result_register_o(up_o),
        .lower_result_register_o(lo_o), .busy_o);
    imdu_gpr_model u_imdu_gpr_model (.clk_i, .wb_i(wb_o));
    initial forever #12.5 clk_i = ~clk_i;
    // ****************
    // shared tasks
    // ****************
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // holds valid up so back-to-back issue is possible
    task automatic issue(imdu_op_e op, logic [31:0] a, logic [31:0] b,
                         logic [4:0] d);
        w = 0;
        req_valid_i <= 1'b1;
        req_i <= '{op, a, b, d};
        @(negedge clk_i);
        while (req_ready_o !== 1'b1 && w < 60) begin
            w++;
            @(negedge clk_i);
        end
        @(posedge clk_i);
    endtask
    task automatic settle;
        int n = 0;
        req_valid_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        while (busy_o !== 1'b0 && n < 60) begin
            n++;
            @(negedge clk_i);
        end
        repeat (2) @(posedge clk_i);
    endtask
    // ****************
    // scenarios
    // ****************
    task t_short;
        issue(IMDU_OP_SIGNED_MULTIPLY, 32'h2, 32'h3, 5'h0);
        issue(IMDU_OP_SIGNED_MULTIPLY, 32'hffff_fffc, 32'h5, 5'h0);
        chk("short wait", 32'h1, w);
        settle;
        chk("short lower", 32'hffff_ffec, lo_o);
        chk("short upper", 32'hffff_ffff, up_o);
        $display("test short done");
    endtask
    task t_long;
        issue(IMDU_OP_SIGNED_MULTIPLY, 32'h1_0000, 32'h1_0000, 5'h0);
        issue(IMDU_OP_UNSIGNED_MULTIPLY, 32'h1_0000, 32'h1_0000, 5'h0);
        chk("long wait", 32'h2, w);
        settle;
        chk("long upper", 32'h1, up_o);
        chk("long lower", 32'h0, lo_o);
        $display("test long done");
    endtask
    task t_mac;
        issue(IMDU_OP_SIGNED_MULTIPLY, 32'h3, 32'h4, 5'h0);
        issue(IMDU_OP_MULTIPLY_ACCUMULATE, 32'h5, 32'h6, 5'h0);
        issue(IMDU_OP_MULTIPLY_SUBTRACT, 32'h2, 32'h1, 5'h0);
        issue(IMDU_OP_UNSIGNED_MULTIPLY_ACCUMULATE, 32'hffff_ffff, 32'h1,
              5'h0);
        issue(IMDU_OP_UNSIGNED_MULTIPLY_SUBTRACT, 32'h1, 32'h1, 5'h0);
        settle;
        chk("mac upper", 32'h1, up_o);
        chk("mac lower", 32'h26, lo_o);
        $display("test mac done");
    endtask
    task t_div;
        issue(IMDU_OP_UNSIGNED_DIVIDE, 32'h64, 32'h7, 5'h0);
        issue(IMDU_OP_MOVE_FROM_LOWER_RESULT, 32'h0, 32'h0, 5'h4);
        chk("move held", 32'h1, 32'(w > 34));
        issue(IMDU_OP_SIGNED_DIVIDE, 32'hffff_fff9, 32'h2, 5'h0);
        issue(IMDU_OP_SIGNED_DIVIDE, 32'hffff_fff9, 32'h2, 5'h0);
        chk("div wait", 32'h23, w);
        issue(IMDU_OP_MOVE_FROM_UPPER_RESULT, 32'h0, 32'h0, 5'h3);
        settle;
        chk("quotient", 32'he, u_imdu_gpr_model.regs_q[4]);
        chk("rem", 32'hffff_ffff, u_imdu_gpr_model.regs_q[3]);
        chk("sdiv lower", 32'hffff_fffd, lo_o);
        $display("test div done");
    endtask
    task t_regmul;
        issue(IMDU_OP_MULTIPLY_TO_REG, 32'h7, 32'h6, 5'h9);
        issue(IMDU_OP_MULTIPLY_TO_REG, 32'h1_0000, 32'h3, 5'ha);
        chk("regmul short wait", 32'h2, w);
        issue(IMDU_OP_MULTIPLY_TO_REG, 32'h1, 32'h1, 5'hb);
        chk("regmul long wait", 32'h4, w);
        settle;
        chk("reg 9", 32'h2a, u_imdu_gpr_model.regs_q[9]);
        chk("reg 10", 32'h3_0000, u_imdu_gpr_model.regs_q[10]);
        chk("lower kept", 32'hffff_fffd, lo_o);
        $display("test regmul done");
    endtask
    initial begin
        #75000;
        errors++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        t_short;
        t_long;
        t_mac;
        t_div;
        t_regmul;
        final_report;
    end
endmodule
